// ==== design/dcs_cmd_status.sv ====
/*
  Drive command word interpreter and status word builder.
  Assumes telegram strobes and drive conditions come from mclk_in
  logic; digital stop inputs arrive from pins.
*/
// Function
// - Bit 06 low ramps to stop on selected ramp; high permits start.
// - Trip reset only on a 0 to 1 edge of bit 07.
// - Bit 08 high makes jog speed the output frequency target.
// - Bit 09 picks ramp pair one when low, pair two when high.
// - A received word with bit 10 low is ignored entirely.
// - Bit 11 drives relay one only when its function selects it.
// - Bit 12 drives relay four only when its function selects it.
// - Bits 14:13 pick set-up one to four under multi set-up.
// - Bit 15 reverses only with serial, OR or AND reversing source.
// - During frequency hold only coast, DC brake or inputs stop.
// - Status bit 00 low on trip, high when control ready.
// - Status bits 03, 04, 06 show trip, error, trip lock.
// - Status bit 05 is reserved and reads zero.
// - Status bit 07 shows any warning.
// - Status bit 08 shows speed equal to reference.
// - Status bit 09 shows bus control possible, low when local.
// - Status bit 10 high while frequency is inside speed limits.
// - Status bit 11 high while stop mode is run or frequency is nonzero.
// - Status bit 12 high during over-temperature auto stop.
// - Status bits 13, 14, 15 show voltage, current, timer limits.
// - Lost link or internal comm fault clears the status word.
// - Speed words are signed, 16384 meaning one hundred percent.
// - Bits 01:00 pick one of four preset references.
// - Bit 02 low DC brakes to stop; high ramps.
// - Bit 03 low coasts immediately; high permits start.
// - Bit 04 low stops on the quick stop ramp.
`timescale 1ns/1ps
`default_nettype none
module dcs_cmd_status
  import dcs_pkg::*;
(
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic telegram_valid_in,
  input wire logic [15:0] drive_command_word_in,
  input wire logic signed [15:0] speed_ref_in,
  input wire dcs_pkg::dcs_cond_type cond_in,
  input wire logic signed [15:0] actual_output_frequency_value_in,
  input wire logic signed [15:0] jog_speed_in,
  input wire logic signed [15:0] speed_low_limit_in,
  input wire logic signed [15:0] speed_high_limit_in,
  input wire logic relay1_func_cmd_in,
  input wire logic relay4_func_cmd_in,
  input wire logic multi_setup_in,
  input wire dcs_pkg::dcs_rev_src_type rev_src_in,
  input wire logic link_ok_in,
  input wire logic comm_fault_in,
  input wire logic di_coast_in,
  input wire logic di_dc_brake_in,
  input wire logic di_reverse_in,
  output dcs_pkg::dcs_act_type act_out,
  output logic trip_reset_out,
  output logic signed [15:0] freq_target_out,
  output logic [15:0] drive_status_word_out,
  output logic signed [15:0] actual_freq_word_out
);
  import dcs_pkg::*;

  logic [2:0] pin_sync;
  logic di_coast;
  logic di_dc_brake;
  logic di_reverse;

  // Pins pass two flops before any use
  dcs_sync #(
    .W(`DCS_SYNC_W)
  ) u_sync (
    .mclk_in(mclk_in),
    .resetn_in(resetn_in),
    .async_in({di_reverse_in, di_dc_brake_in, di_coast_in}),
    .sync_out(pin_sync)
  );

  assign di_coast = pin_sync[0];
  assign di_dc_brake = pin_sync[1];
  assign di_reverse = pin_sync[2];

  // Command capture
  dcs_cmd_type cmd_r;
  dcs_cmd_type cmd_nxt;
  logic signed [15:0] ref_r;
  logic signed [15:0] ref_nxt;
  logic reset_seen_r;
  logic reset_seen_nxt;
  logic trip_reset_r;
  logic trip_reset_nxt;
  dcs_cmd_type rx_cmd;

  assign rx_cmd = dcs_cmd_type'(drive_command_word_in);

  always_comb begin
    cmd_nxt = cmd_r;
    ref_nxt = ref_r;
    reset_seen_nxt = reset_seen_r;
    trip_reset_nxt = 1'b0;
    // One word per telegram, dropped unless marked valid
    if (telegram_valid_in && rx_cmd.data_valid) begin
      cmd_nxt = rx_cmd;
      ref_nxt = speed_ref_in;
      reset_seen_nxt = rx_cmd.reset;
      // Level held high must not re-clear a later trip
      trip_reset_nxt = rx_cmd.reset && !reset_seen_r;
    end
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cmd_r <= dcs_cmd_type'(`DCS_CMD_RESET);
      ref_r <= `DCS_ZERO_WORD;
      reset_seen_r <= 1'b0;
      trip_reset_r <= 1'b0;
    end else begin
      cmd_r <= cmd_nxt;
      ref_r <= ref_nxt;
      reset_seen_r <= reset_seen_nxt;
      trip_reset_r <= trip_reset_nxt;
    end
  end

  assign trip_reset_out = trip_reset_r;

  // Actuator decode
  dcs_act_type act_r;
  dcs_act_type act_nxt;
  logic signed [15:0] target_r;
  logic signed [15:0] target_nxt;
  logic hold;
  logic rev_ok;

  assign hold = !cmd_r.use_ramp;

  always_comb begin
    unique case (rev_src_in)
      DCS_REV_DIGITAL: rev_ok = di_reverse;
      DCS_REV_SERIAL: rev_ok = cmd_r.reverse;
      DCS_REV_OR: rev_ok = cmd_r.reverse || di_reverse;
      DCS_REV_AND: rev_ok = cmd_r.reverse && di_reverse;
    endcase
  end

  always_comb begin
    act_nxt = act_r;
    act_nxt.hold_freq = hold;
    act_nxt.jog = cmd_r.jog;
    act_nxt.ramp2 = cmd_r.ramp2;
    act_nxt.preset_sel = cmd_r.preset_sel;
    act_nxt.relay1 = cmd_r.relay1 && relay1_func_cmd_in;
    act_nxt.relay4 = cmd_r.relay4 && relay4_func_cmd_in;
    // Digital source alone ignores the bus bit
    act_nxt.reverse = rev_ok;
    if (multi_setup_in) begin
      act_nxt.setup_sel = cmd_r.setup_sel;
    end
    // Coast wins over every other stop
    if (!cmd_r.no_coast || di_coast) begin
      act_nxt.stop_mode = DCS_COAST;
    end else if (!cmd_r.ramp_not_dc || di_dc_brake) begin
      act_nxt.stop_mode = DCS_DC_BRAKE;
    end else if (hold) begin
      act_nxt.stop_mode = act_r.stop_mode == DCS_RUN ? DCS_RUN : act_r.stop_mode;
    end else if (!cmd_r.no_quick_stop) begin
      act_nxt.stop_mode = DCS_QUICK_STOP;
    end else if (!cmd_r.start) begin
      act_nxt.stop_mode = DCS_RAMP_STOP;
    end else begin
      act_nxt.stop_mode = DCS_RUN;
    end
  end

  always_comb begin
    target_nxt = target_r;
    // Frozen target while holding frequency
    if (!hold) begin
      if (cmd_r.jog) begin
        target_nxt = jog_speed_in;
      end else begin
        target_nxt = ref_r;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      act_r <= '{stop_mode: DCS_COAST, setup_sel: 2'h0,
                 preset_sel: 2'h0, default: 1'b0};
      target_r <= `DCS_ZERO_WORD;
    end else begin
      act_r <= act_nxt;
      target_r <= target_nxt;
    end
  end

  assign act_out = act_r;
  assign freq_target_out = target_r;

  // Status word
  logic [15:0] status_r;
  logic [15:0] status_nxt;
  logic signed [15:0] afreq_r;
  logic signed [15:0] afreq_nxt;
  logic signed [15:0] freq;

  assign freq = actual_output_frequency_value_in;

  always_comb begin
    status_nxt = `DCS_ZERO_WORD;
    afreq_nxt = freq;
    status_nxt[`DCS_ST_CTRL_READY] = cond_in.ctrl_ready && !cond_in.tripped;
    status_nxt[`DCS_ST_DRIVE_READY] = cond_in.drive_ready && !cond_in.tripped;
    status_nxt[`DCS_ST_ENABLE] = act_r.stop_mode != DCS_COAST && !cond_in.tripped;
    status_nxt[`DCS_ST_TRIP] = cond_in.tripped;
    status_nxt[`DCS_ST_ERROR] = cond_in.error_no_trip;
    status_nxt[`DCS_ST_RESERVED] = 1'b0;
    status_nxt[`DCS_ST_TRIP_LOCK] = cond_in.trip_locked;
    status_nxt[`DCS_ST_WARNING] = cond_in.warning;
    status_nxt[`DCS_ST_AT_SPEED] = freq == target_r;
    status_nxt[`DCS_ST_BUS_CTRL] = !cond_in.local_active;
    // Reaching either limit counts as out of range
    status_nxt[`DCS_ST_FREQ_OK] = freq > speed_low_limit_in &&
                                  freq < speed_high_limit_in;
    status_nxt[`DCS_ST_IN_OPER] = act_r.stop_mode == DCS_RUN ||
                                  freq != `DCS_ZERO_WORD;
    status_nxt[`DCS_ST_AUTO_STOP] = cond_in.overtemp_stop;
    status_nxt[`DCS_ST_VOLT_EXC] = cond_in.dc_volt_bad;
    status_nxt[`DCS_ST_TORQUE_EXC] = cond_in.current_exc;
    status_nxt[`DCS_ST_TIMER_EXC] = cond_in.timer_exc;
    if (!link_ok_in || comm_fault_in) begin
      status_nxt = `DCS_ZERO_WORD;
    end
  end

  // Refreshed every cycle so the next reply is current
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      status_r <= `DCS_ZERO_WORD;
      afreq_r <= `DCS_ZERO_WORD;
    end else begin
      status_r <= status_nxt;
      afreq_r <= afreq_nxt;
    end
  end

  assign drive_status_word_out = status_r;
  assign actual_freq_word_out = afreq_r;
endmodule
`default_nettype wire

// ==== design/dcs_consts.svh ====
/*
  Constants of the drive command and status word logic: status bit
  positions, scaling figures and reset values.
  Assumes inclusion by the package and the main module only.
*/
`ifndef DCS_CONSTS_SVH
`define DCS_CONSTS_SVH

`define DCS_WORD_W 16
`define DCS_SYNC_W 3

`define DCS_ST_CTRL_READY 0
`define DCS_ST_DRIVE_READY 1
`define DCS_ST_ENABLE 2
`define DCS_ST_TRIP 3
`define DCS_ST_ERROR 4
`define DCS_ST_RESERVED 5
`define DCS_ST_TRIP_LOCK 6
`define DCS_ST_WARNING 7
`define DCS_ST_AT_SPEED 8
`define DCS_ST_BUS_CTRL 9
`define DCS_ST_FREQ_OK 10
`define DCS_ST_IN_OPER 11
`define DCS_ST_AUTO_STOP 12
`define DCS_ST_VOLT_EXC 13
`define DCS_ST_TORQUE_EXC 14
`define DCS_ST_TIMER_EXC 15

`define DCS_FULL_SCALE 16'sh4000
`define DCS_POS_MAX 16'sh7FFF
`define DCS_ZERO_WORD 16'h0000
`define DCS_CMD_RESET 16'h0000

`endif

// ==== design/dcs_pkg.sv ====
/*
  Types of the drive command and status word logic.
  Assumes dcs_consts.svh is on the include path.
*/
package dcs_pkg;
  `include "dcs_consts.svh"

  // Command word, bit 15 first
  typedef struct packed {
    logic reverse;
    logic [1:0] setup_sel;
    logic relay4;
    logic relay1;
    logic data_valid;
    logic ramp2;
    logic jog;
    logic reset;
    logic start;
    logic use_ramp;
    logic no_quick_stop;
    logic no_coast;
    logic ramp_not_dc;
    logic [1:0] preset_sel;
  } dcs_cmd_type;

  // Conditions reported by the drive core
  typedef struct packed {
    logic ctrl_ready;
    logic drive_ready;
    logic tripped;
    logic error_no_trip;
    logic trip_locked;
    logic warning;
    logic local_active;
    logic overtemp_stop;
    logic dc_volt_bad;
    logic current_exc;
    logic timer_exc;
  } dcs_cond_type;

  typedef enum logic [1:0] {
    DCS_REV_DIGITAL,
    DCS_REV_SERIAL,
    DCS_REV_OR,
    DCS_REV_AND
  } dcs_rev_src_type;

  typedef enum logic [2:0] {
    DCS_RUN,
    DCS_RAMP_STOP,
    DCS_QUICK_STOP,
    DCS_DC_BRAKE,
    DCS_COAST
  } dcs_stop_type;

  // Commands handed to the motor control
  typedef struct packed {
    dcs_stop_type stop_mode;
    logic hold_freq;
    logic jog;
    logic ramp2;
    logic relay1;
    logic relay4;
    logic reverse;
    logic [1:0] setup_sel;
    logic [1:0] preset_sel;
  } dcs_act_type;
endpackage

// ==== design/dcs_sync.sv ====
/*
  Two flip-flop synchroniser, one stage pair per bit.
  Assumes inputs are asynchronous pins and mclk_in is the control clock.
*/
`timescale 1ns/1ps
`default_nettype none
module dcs_sync #(
  parameter int W = 1
) (
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic meta_r;
      logic hold_r;
      always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
          meta_r <= 1'b0;
          hold_r <= 1'b0;
        end else begin
          meta_r <= async_in[i];
          hold_r <= meta_r;
        end
      end
      assign sync_out[i] = hold_r;
    end
  endgenerate
endmodule
`default_nettype wire

// ==== bench/dcs_assertions.sv ====
/* Port assertions for dcs_cmd_status.
   Assumes the bind below reaches every instance. */
`timescale 1ns/1ps
`default_nettype none
module dcs_chk
  import dcs_pkg::*;
(
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic telegram_valid_in,
  input wire logic [15:0] drive_command_word_in,
  input wire dcs_pkg::dcs_cond_type cond_in,
  input wire logic signed [15:0] actual_output_frequency_value_in,
  input wire logic signed [15:0] speed_low_limit_in,
  input wire logic signed [15:0] speed_high_limit_in,
  input wire logic relay1_func_cmd_in,
  input wire logic link_ok_in,
  input wire logic comm_fault_in,
  input wire dcs_pkg::dcs_act_type act_out,
  input wire logic trip_reset_out,
  input wire logic [15:0] drive_status_word_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);
  logic last7_r;
  logic last7_nxt;
  logic lim;
  logic [15:0] st;
  assign st = drive_status_word_out;
  assign lim = actual_output_frequency_value_in > speed_low_limit_in &&
               actual_output_frequency_value_in < speed_high_limit_in;
  // Refused words must not move the edge reference
  always_comb begin
    last7_nxt = last7_r;
    if (telegram_valid_in && drive_command_word_in[10]) begin
      last7_nxt = drive_command_word_in[7];
    end
  end
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      last7_r <= 1'b0;
    end else begin
      last7_r <= last7_nxt;
    end
  end
  sequence s_link; link_ok_in && !comm_fault_in; endsequence
  sequence s_acc; telegram_valid_in && drive_command_word_in[10]; endsequence
  sequence s_rise; s_acc ##0 (drive_command_word_in[7] && !last7_r); endsequence
  a_status_cleared: assert property (!link_ok_in || comm_fault_in |=> st == 16'h0000)
    else $error("status not cleared");
  a_ready_bit: assert property (s_link |=> st[0] == ($past(cond_in.ctrl_ready) &&
    !$past(cond_in.tripped))) else $error("ready bit wrong");
  a_fault_bits: assert property (s_link |=> {st[6], st[4:3]} == {$past(cond_in.trip_locked),
    $past(cond_in.error_no_trip), $past(cond_in.tripped)}) else $error("fault bits wrong");
  a_reserved_zero: assert property (st[5] == 1'b0) else $error("reserved bit set");
  a_warn_bus: assert property (s_link |=> {st[9], st[7]} == {!$past(cond_in.local_active),
    $past(cond_in.warning)}) else $error("warning or bus bit wrong");
  a_limit_ok: assert property (s_link |=> st[10] == $past(lim))
    else $error("limit bit wrong");
  a_limit_flags: assert property (s_link |=> st[15:12] == {$past(cond_in.timer_exc),
    $past(cond_in.current_exc), $past(cond_in.dc_volt_bad), $past(cond_in.overtemp_stop)})
    else $error("limit flags wrong");
  a_reset_edge: assert property (s_rise |-> ##[1:2] trip_reset_out)
    else $error("trip reset missing");
  a_ramp_pick: assert property (s_acc |-> ##2 act_out.ramp2 == $past(drive_command_word_in[9], 2))
    else $error("ramp pair wrong");
  a_relay_gate: assert property (s_acc |-> ##2 act_out.relay1 ==
    ($past(drive_command_word_in[11], 2) && $past(relay1_func_cmd_in))) else $error("relay wrong");
endmodule
bind dcs_cmd_status dcs_chk chk_u (.mclk_in, .resetn_in, .telegram_valid_in, .drive_command_word_in,
  .cond_in, .actual_output_frequency_value_in, .speed_low_limit_in, .speed_high_limit_in,
  .relay1_func_cmd_in, .link_ok_in, .comm_fault_in, .act_out, .trip_reset_out, .drive_status_word_out);
`default_nettype wire

// ==== bench/dcs_master.sv ====
/* Bus master model sending one telegram per call.
   Assumes calls are not overlapped. */
`timescale 1ns/1ps
`default_nettype none
module dcs_master (
  input wire logic mclk_in,
  output logic telegram_valid_out,
  output logic [15:0] word_out,
  output logic signed [15:0] speed_ref_out
);
  initial begin
    telegram_valid_out = 1'b0;
    word_out = 16'hFFFF;
    speed_ref_out = 16'sh0000;
  end
  task automatic send(input logic [15:0] w);
    @(posedge mclk_in);
    telegram_valid_out <= 1'b1;
    word_out <= w;
    speed_ref_out <= 16'sh4000;
    @(posedge mclk_in);
    telegram_valid_out <= 1'b0;
    // Stale lines show junk, never the last word
    word_out <= ~w;
    speed_ref_out <= ~speed_ref_out;
  endtask
endmodule
`default_nettype wire

// ==== bench/tb.sv ====
/* Self-checking bench for dcs_cmd_status.
   Assumes dcs_master drives the telegram side. */
`timescale 1ns/1ps
`default_nettype none
module tb;
  import dcs_pkg::*;
  logic mclk_in = 1'b0;
  logic resetn_in = 1'b0;
  dcs_cond_type cond = '0;
  logic signed [15:0] freq = 16'sh0000;
  logic signed [15:0] jog = 16'sh04D2;
  logic r1 = 1'b0;
  logic r4 = 1'b0;
  logic ms = 1'b0;
  dcs_rev_src_type rev = DCS_REV_DIGITAL;
  logic link = 1'b1;
  logic flt = 1'b0;
  logic tv;
  logic [15:0] cw;
  logic signed [15:0] sref;
  dcs_act_type act;
  logic trs;
  logic signed [15:0] tgt;
  logic [15:0] drive_status_word;
  logic signed [15:0] afw;
  int n_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  int pulses = 0;
  logic [15:0] wv [5] = '{16'h047C, 16'h0474, 16'h0478, 16'h046C, 16'h043C};
  dcs_stop_type mv [5] = '{DCS_RUN, DCS_COAST, DCS_DC_BRAKE, DCS_QUICK_STOP, DCS_RAMP_STOP};
  logic signed [15:0] fv [4] = '{16'sh0064, 16'sh01F4, 16'sh03E8, 16'shC000};
  dcs_master m_u (.mclk_in(mclk_in), .telegram_valid_out(tv), .word_out(cw), .speed_ref_out(sref));
  dcs_cmd_status dut_u (.mclk_in(mclk_in), .resetn_in(resetn_in), .telegram_valid_in(tv),
    .drive_command_word_in(cw), .speed_ref_in(sref), .cond_in(cond),
    .actual_output_frequency_value_in(freq), .jog_speed_in(jog),
    .speed_low_limit_in(16'sh0064), .speed_high_limit_in(16'sh03E8),
    .relay1_func_cmd_in(r1), .relay4_func_cmd_in(r4), .multi_setup_in(ms), .rev_src_in(rev),
    .link_ok_in(link), .comm_fault_in(flt), .di_coast_in(1'b0), .di_dc_brake_in(1'b0),
    .di_reverse_in(1'b0), .act_out(act), .trip_reset_out(trs), .freq_target_out(tgt),
    .drive_status_word_out(drive_status_word), .actual_freq_word_out(afw));
  initial forever #2 mclk_in = ~mclk_in;
  task automatic close_out;
    $display("Mismatches %0d, comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    if (trs === 1'b1) pulses <= pulses + 1;
    if (cyc == 5000) begin
      n_errors++;
      close_out();
    end
  end
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  task automatic snd(input logic [15:0] w);
    m_u.send(w);
    tick(3);
  endtask
  function automatic logic [15:0] exp_st(input dcs_cond_type c);
    logic [15:0] e;
    e = 16'h0000;
    e[1:0] = {c.drive_ready, c.ctrl_ready} & {2{~c.tripped}};
    e[4:3] = {c.error_no_trip, c.tripped};
    e[7:6] = {c.warning, c.trip_locked};
    e[9] = ~c.local_active;
    e[15:12] = {c.timer_exc, c.current_exc, c.dc_volt_bad, c.overtemp_stop};
    return e;
  endfunction
  initial begin
    int p;
    tick(1);
    chk("rst_status", 16'h0000, drive_status_word);
    chk("rst_stop", 16'(DCS_COAST), 16'(act.stop_mode));
    repeat (3) @(posedge mclk_in);
    resetn_in <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      @(posedge mclk_in);
      cond <= (i < 11) ? dcs_cond_type'(11'h001 << i) : dcs_cond_type'(11'h7FF);
      tick(1);
      chk("status", exp_st(cond), drive_status_word & 16'hF2FB);
    end
    @(posedge mclk_in);
    link <= 1'b0;
    tick(1);
    chk("link_lost", 16'h0000, drive_status_word);
    link <= 1'b1;
    flt <= 1'b1;
    tick(1);
    chk("comm_fault", 16'h0000, drive_status_word);
    flt <= 1'b0;
    cond <= '0;
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk_in);
      freq <= fv[i];
      tick(1);
      chk("limit_ok", {15'h0000, i == 1}, {15'h0000, drive_status_word[10]});
      chk("freq_word", fv[i], afw);
    end
    @(posedge mclk_in);
    freq <= 16'sh0000;
    for (int i = 0; i < 5; i++) begin
      snd(wv[i]);
      chk("stop_mode", 16'(mv[i]), 16'(act.stop_mode));
      chk("in_oper", {15'h0000, i == 0}, {15'h0000, drive_status_word[11]});
    end
    snd(16'h047C);
    snd(16'h041C);
    chk("hold_stop", 16'(DCS_RUN), 16'(act.stop_mode));
    snd(16'h0414);
    chk("hold_coast", 16'(DCS_COAST), 16'(act.stop_mode));
    r1 <= 1'b1;
    ms <= 1'b1;
    rev <= DCS_REV_SERIAL;
    snd(16'hCF7D);
    chk("act", 16'h01D9, 16'(act));
    chk("jog_target", jog, tgt);
    r1 <= 1'b0;
    r4 <= 1'b1;
    rev <= DCS_REV_DIGITAL;
    snd(16'hDF7D);
    chk("act", 16'h01A9, 16'(act));
    snd(16'h0000);
    chk("refused", 16'h01A9, 16'(act));
    p = pulses;
    snd(16'h04FC);
    snd(16'h04FC);
    snd(16'h007C);
    snd(16'h04FC);
    chk("resets", 16'h0001, 16'(pulses - p));
    snd(16'h047C);
    snd(16'h04FC);
    chk("resets", 16'h0002, 16'(pulses - p));
    chk("ref_target", 16'h4000, tgt);
    chk("off_speed", 16'h0000, {15'h0000, drive_status_word[8]});
    freq <= 16'sh4000;
    tick(1);
    tick(1);
    chk("at_speed", 16'h0001, {15'h0000, drive_status_word[8]});
    close_out();
  end
endmodule
`default_nettype wire
